// ---- bench/plvbs_checker.sv ----
// assertions on the ports of the lock detect and band control block
// assumes the block is reached over its own top-level ports only
module plvbs_checker
   import plvbs_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // analogue side
   input wire logic chip_enable,
   input wire logic strength_settled,
   input wire logic phase_err_strobe,
   input wire logic [ERR_WIDTH-1:0] phase_err_ns,
   // pins
   input wire logic status_pin,
   input wire logic txrx_indicator,
   input wire plvbs_cfg_t osc_cfg,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic strobe_q;
   logic [2:0] good_cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // good samples in a row, counted at the pins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         strobe_q <= 1'b0;
         good_cnt <= 3'h0;
      end else begin
         strobe_q <= phase_err_strobe;
         if (!chip_enable)
            good_cnt <= 3'h0;
         else if (phase_err_strobe && !strobe_q)
            good_cnt <= (phase_err_ns >= LOCK_ERR_NS) ? 3'h0 : good_cnt + {2'h0, good_cnt != 3'h7};
      end
   end
   a_lock_after_run: assert property ($rose(status_pin) && osc_cfg.status_sel == SEL_LOCK
      && $stable(osc_cfg) |-> good_cnt >= 3'h5)
      else $error("lock shown before five good samples");
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access not answered after one wait");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_reset_cfg: assert property ($rose(nrst) |-> osc_cfg == 12'h800 && txrx_indicator)
      else $error("configuration not at reset values");
   a_txrx_follow: assert property (txrx_indicator == !osc_cfg.tx_mode)
      else $error("transmit indicator does not follow mode");
   a_pin_txrx: assert property (osc_cfg.status_sel == SEL_TXRX && $past(osc_cfg.status_sel) == SEL_TXRX
      && $stable(osc_cfg) |-> status_pin == txrx_indicator)
      else $error("status pin not showing transmit indicator");
   a_strength_pin: assert property ((strength_settled && chip_enable
      && osc_cfg.status_sel == SEL_STRENGTH) [*6] |-> status_pin)
      else $error("strength ready not shown on status pin");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > OFS_LOCK_INFO
      |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read returned data");
   a_cfg_write: assert property (avs_write && !avs_waitrequest && avs_address == OFS_CFG
      && avs_byteenable == 4'hF |-> ##2 osc_cfg == $past(avs_writedata[11:0], 2))
      else $error("oscillator configuration differs from write");
endmodule
bind plvbs_top plvbs_checker u_checker (.clock(clock), .nrst(nrst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chip_enable(chip_enable),
   .strength_settled(strength_settled), .phase_err_strobe(phase_err_strobe), .phase_err_ns(phase_err_ns),
   .status_pin(status_pin), .txrx_indicator(txrx_indicator), .osc_cfg(osc_cfg), .irq(irq));

// ---- bench/plvbs_host.sv ----
// host model: avalon-mm master that programs the block
// assumes the slave answers with waitrequest; the bench calls access
module plvbs_host
   import plvbs_pkg::*;
(
   // clock
   input wire logic clock,
   // avalon-mm master
   output logic [4:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [3:0] avs_byteenable,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus at time zero
   initial begin
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'h0;
      avs_writedata = 32'h0000_0000;
   end
   // one access, held until waitrequest is sampled low or 50 cycles have passed
   task automatic access(input logic rd, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
      output logic [31:0] q, output logic ok);
      int n;
      @(posedge clock);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      ok = 1'b0;
      q = 32'h0000_0000;
      for (n = 0; n < 50 && !ok; n++) begin
         @(posedge clock);
         ok = !avs_waitrequest;
         q = avs_readdata;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the lock detect and band control block
// assumes plvbs_host drives the register bus; analogue pins are driven here
module testbench import plvbs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, nrst, chip_enable, strength_settled, phase_err_strobe, ok;
   logic [7:0] phase_err_ns;
   logic [4:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, status_pin, txrx_indicator, irq;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd;
   plvbs_cfg_t osc_cfg;
   int err_count = 0;
   int samples_checked = 0;
   // band rows: expected indicator, then configuration word
   logic [12:0] rows [8] = '{13'h1_8C0, 13'h0_8C8, 13'h1_800, 13'h1_8E0, 13'h0_828, 13'h1_410, 13'h1_310, 13'h0_238};
   // lock rows: expected pin, then phase error in ns
   logic [8:0] lk [11] = '{9'h0_0A, 9'h0_03, 9'h0_00, 9'h0_0E, 9'h0_0F, 9'h0_0E, 9'h0_0E, 9'h0_0E, 9'h0_0E,
      9'h1_0E, 9'h1_18};
   plvbs_top dut (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chip_enable(chip_enable),
      .strength_settled(strength_settled), .phase_err_strobe(phase_err_strobe), .phase_err_ns(phase_err_ns),
      .status_pin(status_pin), .txrx_indicator(txrx_indicator), .osc_cfg(osc_cfg), .irq(irq));
   plvbs_host host (.clock(clock), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   // free-running clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic print_verdict();
      if (err_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bad(input logic [31:0] g, input logic [31:0] e);
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
   endtask
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
         bad(g, e);
   endtask
   // pins are looked at once the registered outputs have landed
   task automatic chk_bit(input logic e);
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk_word({31'h0, status_pin}, {31'h0, e});
      @(posedge clock);
   endtask
   task automatic chk_pins(input logic [11:0] c, input logic t, input logic i);
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk_word({18'h0, osc_cfg, txrx_indicator, irq}, {18'h0, c, t, i});
      @(posedge clock);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      host.access(1'b0, a, d, be, rd, ok);
      if (ok !== 1'b1) begin
         err_count++;
         $display("BAD %0t bus write timed out", $time);
         print_verdict();
      end
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      host.access(1'b1, a, 32'h0000_0000, 4'hF, rd, ok);
      if (ok !== 1'b1) begin
         err_count++;
         $display("BAD %0t bus read timed out", $time);
         print_verdict();
      end
      chk_word(rd, e);
   endtask
   // one comparison at the detector, error held around the strobe
   task automatic sample(input logic [7:0] e);
      phase_err_ns <= e;
      repeat (3) @(posedge clock);
      phase_err_strobe <= 1'b1;
      repeat (3) @(posedge clock);
      phase_err_strobe <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   initial begin
      nrst = 1'b0;
      chip_enable = 1'b1;
      strength_settled = 1'b0;
      phase_err_strobe = 1'b0;
      phase_err_ns = 8'h00;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      chk_pins(12'h800, 1'b1, 1'b0);
      rdc(OFS_CFG, 32'h0000_0800);
      rdc(OFS_STATUS, 32'h0000_000C);
      rdc(OFS_INT_MASK, 32'h0000_0000);
      foreach (rows[i]) begin
         wr(OFS_CFG, {20'h0_0000, rows[i][11:0]}, 4'hF);
         rdc(OFS_CFG, {20'h0_0000, rows[i][11:0]});
         chk_pins(rows[i][11:0], rows[i][12], 1'b0);
      end
      wr(OFS_CFG, 32'hFFFF_F3C9, 4'h1);
      wr(5'h14, 32'h0000_0123, 4'hF);
      rdc(OFS_CFG, 32'h0000_02C9);
      rdc(5'h14, 32'h0000_0000);
      wr(OFS_CFG, 32'h0000_0800, 4'hF);
      foreach (lk[i]) begin
         sample(lk[i][7:0]);
         chk_bit(lk[i][8]);
      end
      sample(8'h19);
      chk_bit(1'b0);
      rdc(OFS_INT_STAT, 32'h0000_0003);
      rdc(OFS_LOCK_INFO, 32'h0001_0019);
      wr(OFS_INT_MASK, 32'h0000_0007, 4'hF);
      chk_pins(12'h800, 1'b1, 1'b1);
      wr(OFS_INT_STAT, 32'h0000_0003, 4'hF);
      chk_pins(12'h800, 1'b1, 1'b0);
      wr(OFS_CFG, 32'h0000_0801, 4'hF);
      strength_settled <= 1'b1;
      repeat (6) @(posedge clock);
      chk_bit(1'b1);
      chk_pins(12'h801, 1'b1, 1'b1);
      rdc(OFS_STATUS, 32'h0000_000E);
      rdc(OFS_INT_STAT, 32'h0000_0004);
      wr(OFS_INT_STAT, 32'h0000_0004, 4'hF);
      wr(OFS_CFG, 32'h0000_080A, 4'hF);
      chk_bit(1'b0);
      wr(OFS_CFG, 32'h0000_0802, 4'hF);
      chk_bit(1'b1);
      strength_settled <= 1'b0;
      wr(OFS_CFG, 32'h0000_08C8, 4'hF);
      repeat (5) sample(8'h05);
      chk_bit(1'b1);
      // unused source codes show low even while locked
      wr(OFS_CFG, 32'h0000_08CF, 4'hF);
      chk_bit(1'b0);
      chip_enable <= 1'b0;
      repeat (6) @(posedge clock);
      chk_bit(1'b0);
      chk_pins(12'h800, 1'b1, 1'b1);
      chip_enable <= 1'b1;
      repeat (4) @(posedge clock);
      rdc(OFS_STATUS, 32'h0000_000C);
      rdc(OFS_LOCK_INFO, 32'h0000_0000);
      wr(OFS_CFG, 32'h0000_0231, 4'hF);
      nrst <= 1'b0;
      chk_pins(12'h800, 1'b1, 1'b0);
      chk_word({31'h0, avs_waitrequest}, 32'h0000_0001);
      nrst <= 1'b1;
      rdc(OFS_CFG, 32'h0000_0800);
      print_verdict();
   end
endmodule

// ---- core/plvbs_lockdet.sv ----
// digital lock detector working on one phase error sample per comparison
// assumes sample_valid pulses once per comparison cycle with a stable sample
module plvbs_lockdet
   import plvbs_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // chip disable clears the detector
   input wire logic clear,
   // phase error samples
   input wire logic sample_valid,
   input wire logic [ERR_WIDTH-1:0] sample_ns,
   // lock state and events
   output logic locked,
   output logic [2:0] good_run,
   output logic lock_gain,
   output logic lock_loss
);

   logic small_err;
   logic big_err;

   // classify the present sample
   assign small_err = sample_ns < LOCK_ERR_NS;
   assign big_err = sample_ns >= UNLOCK_ERR_NS;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         good_run <= 3'h0;
      end else if (clear) begin
         good_run <= 3'h0;
      end else if (sample_valid) begin
         if (!small_err) begin
            good_run <= 3'h0;
         end else if (good_run != LOCK_RUN) begin
            good_run <= good_run + 3'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         locked <= 1'b0;
         lock_gain <= 1'b0;
         lock_loss <= 1'b0;
      end else begin
         lock_gain <= 1'b0;
         lock_loss <= 1'b0;
         if (clear) begin
            locked <= 1'b0;
         end else if (sample_valid && locked && big_err) begin
            locked <= 1'b0;
            lock_loss <= 1'b1;
         end else if (sample_valid && !locked && small_err && good_run == LOCK_RUN - 3'h1) begin
            locked <= 1'b1;
            lock_gain <= 1'b1;
         end
      end
   end

endmodule

// ---- core/plvbs_pkg.sv ----
// package for the synthesizer lock detector and oscillator band control
// assumes a 100 MHz system clock and word-aligned avalon-mm register access
package plvbs_pkg;

   // register byte offsets
   localparam logic [4:0] OFS_CFG = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;
   localparam logic [4:0] OFS_INT_STAT = 5'h08;
   localparam logic [4:0] OFS_INT_MASK = 5'h0C;
   localparam logic [4:0] OFS_LOCK_INFO = 5'h10;

   // configuration word field positions
   localparam int CFG_SEL_LSB = 0;
   localparam int CFG_TX_BIT = 3;
   localparam int CFG_CORE_BIT = 4;
   localparam int CFG_HALVER_BIT = 5;
   localparam int CFG_RECENTRE_LSB = 6;
   localparam int CFG_BIAS_LSB = 8;

   // status and interrupt bit positions
   localparam int ST_LOCK_BIT = 0;
   localparam int ST_STRENGTH_BIT = 1;
   localparam int ST_TXRX_BIT = 2;
   localparam int ST_CE_BIT = 3;
   localparam int IRQ_GAIN_BIT = 0;
   localparam int IRQ_LOSS_BIT = 1;
   localparam int IRQ_STRENGTH_BIT = 2;
   localparam int IRQ_WIDTH = 3;

   // status pin source codes
   localparam logic [2:0] SEL_LOCK = 3'h0;
   localparam logic [2:0] SEL_STRENGTH = 3'h1;
   localparam logic [2:0] SEL_TXRX = 3'h2;

   // reset values
   localparam logic [3:0] BIAS_RESET = 4'h8;
   localparam logic [1:0] RECENTRE_RESET = 2'h0;

   // lock detector thresholds in ns of phase error, good-sample run length and error width
   localparam logic [7:0] LOCK_ERR_NS = 8'h0F;
   localparam logic [7:0] UNLOCK_ERR_NS = 8'h19;
   localparam logic [2:0] LOCK_RUN = 3'h5;
   localparam int ERR_WIDTH = 8;

   // oscillator configuration carried to the analogue section
   typedef struct packed {
      logic [3:0] osc_bias_code;
      logic [1:0] osc_recentre_code;
      logic output_halver_enable;
      logic osc_core_select;
      logic tx_mode;
      logic [2:0] status_sel;
   } plvbs_cfg_t;

   // avalon-mm slave request
   typedef struct packed {
      logic [4:0] address;
      logic read;
      logic write;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } plvbs_av_req_t;

endpackage

// ---- core/plvbs_sync.sv ----
// two-flop synchroniser for a group of asynchronous inputs
// assumes each bit is sampled independently; multi-bit values must be held stable
module plvbs_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // async input and synced output
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // one two-flop chain per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               stage1[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               stage1[i] <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate

endmodule

// ---- core/plvbs_top.sv ----
// synthesizer lock detect, status pin and oscillator band configuration
// assumes an avalon-mm master with waitrequest, and analogue pins that are
// asynchronous to the 100 MHz clock; phase error arrives as a value in ns
// held stable around a strobe edge
//
// Our own choices: the Avalon-MM register port and the register addresses.
module plvbs_top
   import plvbs_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // asynchronous analogue side
   input wire logic chip_enable,
   input wire logic strength_settled,
   input wire logic phase_err_strobe,
   input wire logic [ERR_WIDTH-1:0] phase_err_ns,
   // pins and oscillator controls
   output logic status_pin,
   output logic txrx_indicator,
   output plvbs_cfg_t osc_cfg,
   output logic irq
);

   // synchronised inputs
   logic [ERR_WIDTH+2:0] raw_in;
   logic [ERR_WIDTH+2:0] synced;
   logic ce_s;
   logic strength_s;
   logic strobe_s;
   logic strobe_d;
   logic [ERR_WIDTH-1:0] err_s;
   logic sample_valid;

   // register state
   plvbs_av_req_t req;
   plvbs_cfg_t cfg;
   logic [IRQ_WIDTH-1:0] int_stat;
   logic [IRQ_WIDTH-1:0] int_mask;
   logic [IRQ_WIDTH-1:0] events;
   logic [IRQ_WIDTH-1:0] clear_bits;
   logic strength_ready_flag;
   logic strength_d;
   logic [ERR_WIDTH-1:0] last_err;
   logic [7:0] loss_count;

   // detector outputs
   logic locked;
   logic [2:0] good_run;
   logic lock_gain;
   logic lock_loss;

   // bus decode
   logic wr_take;
   logic rd_take;
   logic [31:0] next_readdata;
   logic next_status_pin;
   logic [31:0] cfg_merged;

   // byte-enable merge used by the configuration register
   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0] be
   );
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // configuration word as software sees it
   function automatic logic [31:0] cfg_word(input plvbs_cfg_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CFG_SEL_LSB +: 3] = c.status_sel;
      w[CFG_TX_BIT] = c.tx_mode;
      w[CFG_CORE_BIT] = c.osc_core_select;
      w[CFG_HALVER_BIT] = c.output_halver_enable;
      w[CFG_RECENTRE_LSB +: 2] = c.osc_recentre_code;
      w[CFG_BIAS_LSB +: 4] = c.osc_bias_code;
      return w;
   endfunction

   // gather the bus signals into one request
   assign req.address = avs_address;
   assign req.read = avs_read;
   assign req.write = avs_write;
   assign req.byteenable = avs_byteenable;
   assign req.writedata = avs_writedata;

   // configuration word with the written byte lanes merged in
   assign cfg_merged = merge_bytes(cfg_word(cfg), req.writedata, req.byteenable);

   // every analogue input passes two flip-flops
   assign raw_in = {chip_enable, strength_settled, phase_err_strobe, phase_err_ns};

   plvbs_sync #(
      .WIDTH(ERR_WIDTH + 3)
   ) u_sync (
      .clock(clock),
      .nrst(nrst),
      .async_in(raw_in),
      .sync_out(synced)
   );

   assign ce_s = synced[ERR_WIDTH+2];
   assign strength_s = synced[ERR_WIDTH+1];
   assign strobe_s = synced[ERR_WIDTH];
   assign err_s = synced[ERR_WIDTH-1:0];

   // strobe delay for edge detection
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         strobe_d <= 1'b0;
      end else begin
         strobe_d <= strobe_s;
      end
   end

   assign sample_valid = strobe_s && !strobe_d;

   plvbs_lockdet u_lockdet (
      .clock(clock),
      .nrst(nrst),
      .clear(!ce_s),
      .sample_valid(sample_valid),
      .sample_ns(err_s),
      .locked(locked),
      .good_run(good_run),
      .lock_gain(lock_gain),
      .lock_loss(lock_loss)
   );

   // last sample and lock loss tally for software
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         last_err <= 8'h00;
         loss_count <= 8'h00;
      end else if (!ce_s) begin
         last_err <= 8'h00;
         loss_count <= 8'h00;
      end else begin
         if (sample_valid) begin
            last_err <= err_s;
         end
         if (lock_loss && loss_count != 8'hFF) begin
            loss_count <= loss_count + 8'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         strength_ready_flag <= 1'b0;
         strength_d <= 1'b0;
      end else begin
         strength_ready_flag <= strength_s && ce_s;
         strength_d <= strength_ready_flag;
      end
   end

   // bus handshake: one wait cycle, then the access completes
   assign wr_take = req.write && !avs_waitrequest;
   assign rd_take = req.read && !avs_waitrequest;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((req.read || req.write) && avs_waitrequest);
      end
   end

   // configuration register, cleared by chip disable
   // internal core after reset
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cfg.status_sel <= SEL_LOCK;
         cfg.tx_mode <= 1'b0;
         cfg.osc_core_select <= 1'b0;
         cfg.output_halver_enable <= 1'b0;
         cfg.osc_recentre_code <= RECENTRE_RESET;
         cfg.osc_bias_code <= BIAS_RESET;
      end else if (!ce_s) begin
         cfg.status_sel <= SEL_LOCK;
         cfg.tx_mode <= 1'b0;
         cfg.osc_core_select <= 1'b0;
         cfg.output_halver_enable <= 1'b0;
         cfg.osc_recentre_code <= RECENTRE_RESET;
         cfg.osc_bias_code <= BIAS_RESET;
      end else if (wr_take && req.address == OFS_CFG) begin
         cfg.status_sel <= cfg_merged[CFG_SEL_LSB +: 3];
         cfg.tx_mode <= cfg_merged[CFG_TX_BIT];
         cfg.osc_core_select <= cfg_merged[CFG_CORE_BIT];
         cfg.output_halver_enable <= cfg_merged[CFG_HALVER_BIT];
         cfg.osc_recentre_code <= cfg_merged[CFG_RECENTRE_LSB +: 2];
         cfg.osc_bias_code <= cfg_merged[CFG_BIAS_LSB +: 4];
      end
   end

   // oscillator controls to the analogue section, one cycle after the register
   // halver sits outside the loop
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         osc_cfg <= '0;
         osc_cfg.osc_bias_code <= BIAS_RESET;
      end else begin
         osc_cfg <= cfg;
      end
   end

   // interrupt events
   assign events[IRQ_GAIN_BIT] = lock_gain;
   assign events[IRQ_LOSS_BIT] = lock_loss;
   assign events[IRQ_STRENGTH_BIT] = strength_ready_flag && !strength_d;

   // write-one-to-clear bits of the interrupt status register
   assign clear_bits = (wr_take && req.address == OFS_INT_STAT && req.byteenable[0])
      ? req.writedata[IRQ_WIDTH-1:0] : '0;

   // sticky status, a new event wins over a clear
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         int_stat <= '0;
      end else begin
         int_stat <= (int_stat & ~clear_bits) | events;
      end
   end

   // interrupt mask
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         int_mask <= '0;
      end else if (wr_take && req.address == OFS_INT_MASK && req.byteenable[0]) begin
         int_mask <= req.writedata[IRQ_WIDTH-1:0];
      end
   end

   // level interrupt from unmasked sticky bits
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((int_stat & ~clear_bits) | events) & int_mask);
      end
   end

   // read multiplexer, unmapped addresses read zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (req.address)
         OFS_CFG: begin
            next_readdata = cfg_word(cfg);
         end
         OFS_STATUS: begin
            next_readdata[ST_LOCK_BIT] = locked;
            next_readdata[ST_STRENGTH_BIT] = strength_ready_flag;
            next_readdata[ST_TXRX_BIT] = !cfg.tx_mode;
            next_readdata[ST_CE_BIT] = ce_s;
         end
         OFS_INT_STAT: begin
            next_readdata[IRQ_WIDTH-1:0] = int_stat;
         end
         OFS_INT_MASK: begin
            next_readdata[IRQ_WIDTH-1:0] = int_mask;
         end
         OFS_LOCK_INFO: begin
            next_readdata[7:0] = last_err;
            next_readdata[10:8] = good_run;
            next_readdata[23:16] = loss_count;
         end
         default: begin
            next_readdata = 32'h0000_0000;
         end
      endcase
   end

   // read data captured in the wait cycle, stands at the completing edge
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (req.read && avs_waitrequest) begin
         avs_readdata <= next_readdata;
      end else if (rd_take) begin
         avs_readdata <= avs_readdata;
      end
   end

   // status pin source selection
   // three-bit source select
   always_comb begin
      next_status_pin = 1'b0;
      unique case (cfg.status_sel)
         SEL_LOCK: begin
            next_status_pin = locked;
         end
         SEL_STRENGTH: begin
            next_status_pin = strength_ready_flag;
         end
         SEL_TXRX: begin
            next_status_pin = !cfg.tx_mode;
         end
         default: begin
            next_status_pin = 1'b0;
         end
      endcase
   end

   // registered pins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         status_pin <= 1'b0;
         txrx_indicator <= 1'b1;
      end else begin
         status_pin <= next_status_pin;
         txrx_indicator <= !cfg.tx_mode;
      end
   end

endmodule
